// ==== shared/fps_pkg.sv ====
// package: constants, codes and carriers of the flash program/erase sequencer
`default_nettype none
package fps_pkg;
  // ****************************************
  // register offsets (register port, word index)
  // ****************************************
  localparam logic [3:0] PROG_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h1;
  localparam logic [3:0] CONFIG_OFS = 4'h2;
  // ****************************************
  // operation codes
  // ****************************************
  localparam logic [7:0] OP_IDLE       = 8'h00;
  localparam logic [7:0] OP_WRITE_VER  = 8'h61;
  localparam logic [7:0] OP_WRITE      = 8'hA1;
  localparam logic [7:0] OP_PAGE_ONE   = 8'h92;
  localparam logic [7:0] OP_PAGE_CONT  = 8'hA2;
  localparam logic [7:0] OP_SECT_ONE   = 8'h94;
  localparam logic [7:0] OP_SECT_CONT  = 8'hA4;
  localparam logic [7:0] OP_VERIFY_ONE = 8'hD0;
  localparam logic [7:0] OP_VERIFY_CNT = 8'hE0;
  localparam logic [7:0] OP_INVALIDATE = 8'hC1;
  // ****************************************
  // field positions
  // ****************************************
  localparam int STS_BUSY_BIT   = 0;
  localparam int STS_SLEEP_BIT  = 1;
  localparam int STS_VERIFY_ERROR_FLAG_BIT   = 2;
  localparam int CFG_HARDREAD_LEVEL_LSB  = 1;
  localparam int CFG_SECP_LSB   = 4;
  localparam int CFG_INT_BIT    = 14;
  localparam int CFG_PWR_BIT    = 15;
  localparam logic [15:0] CFG_RESET  = 16'h8000;
  localparam logic [15:0] CFG_WMASK  = 16'hDFF6;
  // ****************************************
  // hardread levels
  // ****************************************
  localparam logic [1:0] HR_NORMAL  = 2'h0;
  localparam logic [1:0] HR_WRITTEN = 2'h1;
  localparam logic [1:0] HR_ERASED  = 2'h2;
  // ****************************************
  // timing, in ns, and derived cycle counts at 10 MHz
  // ****************************************
  localparam int CLK_NS     = 100;
  localparam int T_PROG_NS  = 102000;
  localparam int T_ERASE_NS = 5000000;
  localparam int T_VER_NS   = 3000;
  localparam int T_SLEEP_NS = 2000;
  localparam int T_WAKE_NS  = 3000;
  localparam int C_PROG     = (T_PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_ERASE    = (T_ERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_VER      = (T_VER_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_SLEEP    = (T_SLEEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_WAKE     = (T_WAKE_NS + CLK_NS - 1) / CLK_NS;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } fps_reg_req_t;
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } fps_arr_req_t;
  typedef struct packed {
    logic        prog;
    logic        erase_page;
    logic        erase_sect;
    logic        verify;
    logic        invalidate;
    logic [1:0]  hardread;
    logic [15:0] addr;
    logic [31:0] wdata;
  } fps_flash_cmd_t;
endpackage : fps_pkg
`default_nettype wire

// ==== rtl/fps_sequencer.sv ====
// flash program/erase/verify sequencer with sleep control and access stall
// Operation
// - codes 61h and A1h start continuous block write, with or without verification
// - in write mode a block write to the array triggers programming of it
// - busy set while sequence runs; ready interrupt on completion if enabled
// - array write or register write during an operation is dropped; stall flags it one cycle later
// - continuous mode persists until code 00h is written
// - auto-verified write reports outcome in the verify error flag
// - code 92h one-shot page erase triggered by dummy word write
// - code A2h continuous page erase per dummy word write
// - code 94h one-shot sector erase triggered by dummy word write
// - code A4h continuous sector erase per dummy word write
// - code D0h one-shot verify compares reference block with array
// - code E0h continuous verify compares each block until 00h
// - two-bit incremental updates keep ECC and parity erased, 32 times
// - invalidation write keeps data, programs three ECC and one parity bit
// - sleep request or power-off clears to sleep; busy and sleep flags shown
// - wake-up with power bit set wakes; flags clear; ready interrupt raised if enabled
// - early wake-up does not shorten sleep entry; wake follows directly
// - ready interrupt enable gates completion interrupts
// - hardread level 00 normal, 01 written, 10 erased, 11 reserved
// - accesses to protected sectors are accepted but ignored
//
// Design decisions made here: the address map and strobed register access.
`default_nettype none
module fps_sequencer #(
  parameter int C_PROG_P   = fps_pkg::C_PROG,
  parameter int C_ERASE_P  = fps_pkg::C_ERASE,
  parameter int SECT_SHIFT = 12
) (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire fps_pkg::fps_reg_req_t   reg_req,
  output logic [31:0]                  reg_rdata,
  input  wire fps_pkg::fps_arr_req_t   arr_req,
  output logic                         stall,
  input  wire logic                    cpu_sleep_req,
  input  wire logic                    wake_event,
  output fps_pkg::fps_flash_cmd_t      flash_cmd,
  input  wire logic                    flash_done,
  input  wire logic                    flash_mismatch,
  output logic                         ready_irq
);
  import fps_pkg::*;

  typedef enum {S_ACTIVE, S_RUN, S_GO_SLEEP, S_SLEEP, S_WAKE} fps_state_t;

  typedef struct packed {
    fps_state_t     st;
    logic [7:0]     action;
    logic [15:0]    cfg;
    logic           verify_error_flag;
    logic           pend_wake;
    logic           sleep_flag;
    logic [22:0]    cnt;
    logic           use_done;
    logic           stall;
    logic           irq;
    logic [31:0]    rdata;
    fps_flash_cmd_t cmd;
  } fps_regs_t;

  fps_regs_t r_r;
  fps_regs_t r_nxt;

  logic       is_op;
  logic       busy;
  logic [7:0] sect;
  logic       prot;
  logic       one_shot;

  assign busy  = (r_r.st == S_RUN) || (r_r.st == S_GO_SLEEP) || (r_r.st == S_WAKE);
  // sector index from the word address; bits above the port read as zero
  assign sect  = 8'(arr_req.addr >> SECT_SHIFT);
  // one-shot codes fall back to 00h after their single step, protected or not
  assign one_shot = (r_r.action[7:4] == 4'h9) || (r_r.action == OP_VERIFY_ONE) || (r_r.action == OP_INVALIDATE);
  assign prot  = sect < r_r.cfg[CFG_SECP_LSB +: 8];
  assign is_op = r_r.action != OP_IDLE;

  assign reg_rdata = r_r.rdata;
  assign stall     = r_r.stall;
  assign flash_cmd = r_r.cmd;
  assign ready_irq = r_r.irq;

  always_comb begin
    r_nxt          = r_r;
    r_nxt.irq      = 1'b0;
    r_nxt.rdata    = 32'h0000_0000;
    r_nxt.cmd.prog = 1'b0;
    r_nxt.cmd.erase_page = 1'b0;
    r_nxt.cmd.erase_sect = 1'b0;
    r_nxt.cmd.verify     = 1'b0;
    r_nxt.cmd.invalidate = 1'b0;
    if (wake_event) begin
      r_nxt.pend_wake = 1'b1;
    end
    // ****************************************
    // register port; writes during busy are dropped and flagged by the stall
    // ****************************************
    if (reg_req.rd) begin
      case (reg_req.addr)
        PROG_OFS:   r_nxt.rdata = {24'h00_0000, r_r.action};
        STATUS_OFS: r_nxt.rdata = {29'h0000_0000, r_r.verify_error_flag, r_r.sleep_flag, busy};
        CONFIG_OFS: r_nxt.rdata = {16'h0000, r_r.cfg};
        default:    r_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (reg_req.wr && !busy) begin
      case (reg_req.addr)
        PROG_OFS: begin
          r_nxt.action = reg_req.wdata[7:0];
          if (reg_req.wdata[7:0] == OP_WRITE_VER || reg_req.wdata[7:0] == OP_VERIFY_ONE
              || reg_req.wdata[7:0] == OP_VERIFY_CNT) begin
            r_nxt.verify_error_flag = 1'b0;
          end
        end
        CONFIG_OFS: r_nxt.cfg = reg_req.wdata[15:0] & CFG_WMASK;
        default: ;
      endcase
    end
    // flag, one cycle later, a register write or array write made while busy
    r_nxt.stall = busy && (reg_req.wr || arr_req.wr);
    case (r_r.st)
      S_ACTIVE: begin
        if (cpu_sleep_req || !r_r.cfg[CFG_PWR_BIT]) begin
          r_nxt.st         = S_GO_SLEEP;
          r_nxt.sleep_flag = 1'b1;
          r_nxt.cnt        = 23'(C_SLEEP);
          r_nxt.pend_wake  = wake_event;
        end else if (arr_req.wr && is_op) begin
          r_nxt.cmd.addr     = arr_req.addr;
          r_nxt.cmd.wdata    = arr_req.wdata;
          r_nxt.cmd.hardread = r_r.cfg[CFG_HARDREAD_LEVEL_LSB +: 2];
          if (prot) begin
            r_nxt.action = one_shot ? OP_IDLE : r_r.action;
          end else begin
            r_nxt.st       = S_RUN;
            r_nxt.use_done = 1'b1;
            r_nxt.cnt      = 23'(C_PROG_P);
            case (r_r.action)
              OP_WRITE_VER, OP_WRITE: r_nxt.cmd.prog = 1'b1;
              OP_PAGE_ONE, OP_PAGE_CONT: begin
                r_nxt.cmd.erase_page = 1'b1;
                r_nxt.cnt            = 23'(C_ERASE_P);
              end
              OP_SECT_ONE, OP_SECT_CONT: begin
                r_nxt.cmd.erase_sect = 1'b1;
                r_nxt.cnt            = 23'(C_ERASE_P);
              end
              OP_VERIFY_ONE, OP_VERIFY_CNT: begin
                r_nxt.cmd.verify = 1'b1;
                r_nxt.cnt        = 23'(C_VER);
              end
              OP_INVALIDATE: r_nxt.cmd.invalidate = 1'b1;
              default: begin
                r_nxt.st       = S_ACTIVE;
                r_nxt.use_done = 1'b0;
              end
            endcase
          end
        end
      end
      S_RUN: begin
        if (r_r.cnt != 23'h00_0000) begin
          r_nxt.cnt = r_r.cnt - 23'h00_0001;
        end
        if (flash_done || (r_r.cnt == 23'h00_0000)) begin
          r_nxt.st       = S_ACTIVE;
          r_nxt.use_done = 1'b0;
          r_nxt.irq      = r_r.cfg[CFG_INT_BIT];
          // judge by the mode: the command pulse lasts one cycle only
          if ((r_r.action == OP_WRITE_VER || r_r.action == OP_VERIFY_ONE || r_r.action == OP_VERIFY_CNT)
              && flash_mismatch) begin
            r_nxt.verify_error_flag = 1'b1;
          end
          if (one_shot) begin
            r_nxt.action = OP_IDLE;
          end
        end
      end
      S_GO_SLEEP: begin
        // entry always runs out before wake is looked at
        r_nxt.cnt = r_r.cnt - 23'h00_0001;
        if (r_r.cnt == 23'h00_0001) begin
          if ((r_r.pend_wake || wake_event) && r_r.cfg[CFG_PWR_BIT]) begin
            r_nxt.st  = S_WAKE;
            r_nxt.cnt = 23'(C_WAKE);
          end else begin
            r_nxt.st = S_SLEEP;
          end
          r_nxt.pend_wake = 1'b0;
        end
      end
      S_SLEEP: begin
        if (wake_event && r_r.cfg[CFG_PWR_BIT]) begin
          r_nxt.st  = S_WAKE;
          r_nxt.cnt = 23'(C_WAKE);
        end
      end
      S_WAKE: begin
        r_nxt.cnt = r_r.cnt - 23'h00_0001;
        if (r_r.cnt == 23'h00_0001) begin
          r_nxt.st         = S_ACTIVE;
          r_nxt.sleep_flag = 1'b0;
          r_nxt.irq        = r_r.cfg[CFG_INT_BIT];
          r_nxt.pend_wake  = 1'b0;
        end
      end
      default: r_nxt.st = S_ACTIVE;
    endcase
    if (r_nxt.st != S_ACTIVE && r_r.st == S_ACTIVE && r_nxt.st != S_RUN) begin
      r_nxt.stall = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r_r            <= '0;
      r_r.st         <= S_ACTIVE;
      r_r.cfg        <= CFG_RESET;
    end else begin
      r_r <= r_nxt;
    end
  end
endmodule : fps_sequencer
`default_nettype wire

// ==== tb/fps_seq_properties.sv ====
// checker: port-level properties of the sequencer
`default_nettype none
module fps_seq_properties (
  input wire logic                    clk,
  input wire logic                    srst,
  input wire fps_pkg::fps_reg_req_t   reg_req,
  input wire logic [31:0]             reg_rdata,
  input wire fps_pkg::fps_arr_req_t   arr_req,
  input wire logic                    stall,
  input wire fps_pkg::fps_flash_cmd_t flash_cmd,
  input wire logic                    ready_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  import fps_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [4:0] cmd_vec;
  assign cmd_vec = {flash_cmd.prog, flash_cmd.erase_page, flash_cmd.erase_sect, flash_cmd.verify,
                    flash_cmd.invalidate};
  cmd_cause_a: assert property (|cmd_vec |-> $past(arr_req.wr))
    else $error("command pulse without array write");
  cmd_payload_a: assert property (|cmd_vec |-> flash_cmd.addr == $past(arr_req.addr)
    && flash_cmd.wdata == $past(arr_req.wdata))
    else $error("command payload differs from array write");
  cmd_kind_a: assert property ($onehot0(cmd_vec))
    else $error("two command kinds at once");
  busy_gap_a: assert property (|cmd_vec |=> !(|cmd_vec) [*2])
    else $error("command while busy");
  stall_cause_a: assert property (stall |-> $past(reg_req.wr || arr_req.wr))
    else $error("stall without a write");
  stall_drop_a: assert property (stall |-> cmd_vec == 5'h00)
    else $error("stalled access still issued");
  irq_pulse_a: assert property (ready_irq |=> !ready_irq)
    else $error("ready interrupt longer than one cycle");
  read_idle_a: assert property (!reg_req.rd |=> reg_rdata == 32'h0)
    else $error("read data outside read answer");
endmodule : fps_seq_properties
`default_nettype wire

// ==== tb/fps_flash_model.sv ====
// partner: flash array answering sequencer commands
`default_nettype none
module fps_flash_model (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire fps_pkg::fps_flash_cmd_t flash_cmd,
  input  wire logic                    slow,
  input  wire logic                    bad,
  output logic                         flash_done,
  output logic                         flash_mismatch
);
  timeunit 1ns;
  timeprecision 1ns;
  import fps_pkg::*;
  logic [5:0] cnt_r;
  logic       tog_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= 6'h00;
      tog_r <= 1'b0;
    end else begin
      tog_r <= ~tog_r;
      if (flash_cmd.prog | flash_cmd.erase_page | flash_cmd.erase_sect | flash_cmd.verify | flash_cmd.invalidate)
        cnt_r <= slow ? 6'h0C : 6'h03;
      else if (cnt_r != 6'h00)
        cnt_r <= cnt_r - 6'h01;
    end
  end
  assign flash_done = (cnt_r == 6'h01);
  // compare line carries no result outside done, so keep it moving
  assign flash_mismatch = flash_done ? bad : tog_r;
endmodule : fps_flash_model
`default_nettype wire

// ==== tb/fps_sequencer_tb.sv ====
// testbench: self-checking run of the sequencer against the array model
`default_nettype none
module fps_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fps_pkg::*;
  logic           clk, srst, cpu_sleep_req, wake_event, slow, bad, flash_done, flash_mismatch, stall, ready_irq;
  fps_reg_req_t   reg_req;
  fps_arr_req_t   arr_req;
  fps_flash_cmd_t flash_cmd;
  logic [31:0]    reg_rdata, got;
  logic [7:0]     code;
  logic [4:0]     kind;
  logic [4:0]     cmd_seen;
  assign cmd_seen = {flash_cmd.prog, flash_cmd.erase_page, flash_cmd.erase_sect, flash_cmd.verify,
                     flash_cmd.invalidate};
  int             fail_count, total_checks, seed, irqs, base, n;
  // erase codes lead so every write lands on erased blocks
  logic [7:0] codes [9] = '{8'h92, 8'hA2, 8'h94, 8'hA4, 8'h61, 8'hA1, 8'hD0, 8'hE0, 8'hC1};
  fps_sequencer #(.C_PROG_P(20), .C_ERASE_P(20)) dut (.clk(clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .arr_req(arr_req), .stall(stall), .cpu_sleep_req(cpu_sleep_req), .wake_event(wake_event), .flash_cmd(flash_cmd),
    .flash_done(flash_done), .flash_mismatch(flash_mismatch), .ready_irq(ready_irq));
  fps_flash_model partner (.clk(clk), .srst(srst), .flash_cmd(flash_cmd), .slow(slow), .bad(bad),
    .flash_done(flash_done), .flash_mismatch(flash_mismatch));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (ready_irq === 1'b1) irqs++;
  // ****************************************
  // bus tasks and expectations
  // ****************************************
  function automatic logic [4:0] kind_of(input logic [7:0] c);
    case (c)
      OP_WRITE_VER, OP_WRITE:       return 5'h10;
      OP_PAGE_ONE, OP_PAGE_CONT:    return 5'h08;
      OP_SECT_ONE, OP_SECT_CONT:    return 5'h04;
      OP_VERIFY_ONE, OP_VERIFY_CNT: return 5'h02;
      default:                      return 5'h01;
    endcase
  endfunction : kind_of
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic rw(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
    #1 got = reg_rdata;
  endtask : rw
  // sectors 4..7 only, word aligned, so protection never hits by chance
  task automatic aw(input logic pick, input logic [15:0] a, input logic [4:0] ek, input logic es);
    @(posedge clk);
    arr_req <= '{wr: 1'b1, addr: pick ? {2'b01, 12'($random(seed)), 2'b00} : a, wdata: $random(seed)};
    @(posedge clk);
    arr_req <= '0;
    #1 chk(cmd_seen, ek);
    chk(stall, es);
  endtask : aw
  task automatic idle();
    n = 0;
    do begin
      rw(1'b0, STATUS_OFS, 32'h0);
      n++;
    end while (got[STS_BUSY_BIT] !== 1'b0 && n < 300);
    if (got[STS_BUSY_BIT] !== 1'b0) begin
      fail_count++;
      conclude();
    end
  endtask : idle
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    srst = 1'b1;
    reg_req = '0;
    arr_req = '0;
    cpu_sleep_req = 1'b0;
    wake_event = 1'b0;
    slow = 1'b0;
    bad = 1'b0;
    seed = 75048;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rw(1'b0, CONFIG_OFS, 32'h0);
    chk(got, {16'h0, CFG_RESET});
    rw(1'b0, STATUS_OFS, 32'h0);
    chk(got, 32'h0);
    $display("test reset done");
    foreach (codes[i]) begin
      code = codes[i];
      kind = kind_of(code);
      slow <= i[0];
      bad <= (code == OP_VERIFY_ONE);
      base = irqs;
      rw(1'b1, CONFIG_OFS, {16'h0, CFG_RESET | (i[1] ? 16'h4000 : 16'h0) | 16'h0002});
      rw(1'b1, PROG_OFS, {24'h0, code});
      aw(1'b1, 16'h0, kind, 1'b0);
      if (kind[1]) chk(flash_cmd.hardread, HR_WRITTEN);
      aw(1'b1, 16'h0, 5'h00, 1'b1);
      idle();
      rw(1'b0, PROG_OFS, 32'h0);
      chk(got, code[5] ? code : 8'h00);
      aw(1'b1, 16'h0, code[5] ? kind : 5'h00, 1'b0);
      idle();
      rw(1'b1, PROG_OFS, 32'h0);
      aw(1'b1, 16'h0, 5'h00, 1'b0);
      rw(1'b0, STATUS_OFS, 32'h0);
      if (code inside {OP_WRITE_VER, OP_VERIFY_ONE, OP_VERIFY_CNT}) chk(got[STS_VERIFY_ERROR_FLAG_BIT], bad);
      if (!kind[1]) chk(irqs - base, i[1] ? (code[5] ? 2 : 1) : 0);
      $display("test code %h done", code);
    end
    rw(1'b1, CONFIG_OFS, 32'h8020);
    rw(1'b1, PROG_OFS, {24'h0, OP_SECT_ONE});
    aw(1'b0, 16'h1FFC, 5'h00, 1'b0);
    rw(1'b0, PROG_OFS, 32'h0);
    chk(got, 32'h0);
    $display("test protection done");
    rw(1'b1, CONFIG_OFS, 32'h4000);
    rw(1'b0, STATUS_OFS, 32'h0);
    chk(got, 32'h3);
    idle();
    chk(got, 32'h2);
    base = irqs;
    rw(1'b1, CONFIG_OFS, 32'hC000);
    @(posedge clk) wake_event <= 1'b1;
    @(posedge clk) wake_event <= 1'b0;
    rw(1'b0, STATUS_OFS, 32'h0);
    chk(got, 32'h3);
    idle();
    chk(got, 32'h0);
    chk(irqs - base, 1);
    @(posedge clk) cpu_sleep_req <= 1'b1;
    @(posedge clk) cpu_sleep_req <= 1'b0;
    @(posedge clk) wake_event <= 1'b1;
    @(posedge clk) wake_event <= 1'b0;
    idle();
    chk(n * 2 >= C_SLEEP + C_WAKE - 6, 1);
    chk(got, 32'h0);
    $display("test sleep done");
    conclude();
  end
endmodule : fps_sequencer_tb
bind fps_sequencer fps_seq_properties props (.clk(clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .arr_req(arr_req), .stall(stall), .flash_cmd(flash_cmd), .ready_irq(ready_irq));
`default_nettype wire
